// file: common/remap_router_regs.svh
// register offsets, selector codes and reset values of the pin router
`ifndef REMAP_ROUTER_REGS_SVH
`define REMAP_ROUTER_REGS_SVH

`define RR_ADDR_W 12
`define RR_IN_SEL_BASE 12'h000
`define RR_STATUS_OFS 12'h0f0
`define RR_ROUTED_OFS 12'h0f4
`define RR_OUT_SEL_BASE 12'h100
`define RR_IN_RESET 8'h00
`define RR_OUT_RESET 6'h00

`define RR_IN_TIE_LOW 8'h00
`define RR_IN_COMPARATOR1_VIRTUAL_SOURCE 8'h01
`define RR_IN_CMP2 8'h02
`define RR_IN_CMP3 8'h03
`define RR_IN_CMP4 8'h04
`define RR_IN_CMP5 8'h0c
`define RR_IN_VIRT_FIRST 8'hb0
`define RR_IN_VIRT_LAST 8'hb5
`define RR_IN_PIN_MASK 128'hf3c00003_c0000160_b7ffffff_1b1f0000

`define RR_NUM_REMAP 182
`define RR_NUM_PADS 128
`define RR_VIRT_FIRST_PIN 176
`define RR_OUT_IMPL_MASK 182'h3f0000_00000000_e1400002_00000060_03c30ff8_00100000

`define RR_OUT_NULL 6'h00
`define RR_OUT_UART1_TX 6'h01
`define RR_OUT_UART2_TX 6'h03
`define RR_OUT_SPI2_DATA 6'h08
`define RR_OUT_SPI2_CLK 6'h09
`define RR_OUT_SPI2_SEL 6'h0a
`define RR_OUT_CAN_TX 6'h0e
`define RR_OUT_COMPARE1 6'h10
`define RR_OUT_COMPARATOR1 6'h18
`define RR_OUT_PWM_SYNC 6'h2d
`define RR_OUT_REF_CLK 6'h31
`define RR_OUT_COMPARATOR4 6'h32
`define RR_OUT_SENT1 6'h39

`endif

// file: common/remap_router_pkg.sv
// types shared by the pin router modules
package remap_router_pkg;
  typedef logic [7:0] in_sel_t;
  typedef logic [5:0] out_sel_t;
  typedef enum int {
    IN_EXT_EXT_INTERRUPT_1, IN_EXT_EXT_INTERRUPT_2, IN_TIMER2_CLK, IN_CAPTURE1, IN_CAPTURE2,
    IN_CAPTURE3, IN_CAPTURE4, IN_COMPARE_FAULT_A, IN_PWM_FAULT1,
    IN_PWM_FAULT2, IN_UART1_RX, IN_UART2_RX, IN_SPI2_DATA, IN_SPI2_CLK,
    IN_SPI2_SEL, IN_CAN_RX, IN_PWM_SYNC, IN_DEADTIME1, IN_DEADTIME2,
    IN_DEADTIME3, IN_SENT1, IN_SENT2, IN_COUNT
  } in_route_t;
endpackage

// file: src/input_route_mux.sv
// source selector for one remappable peripheral input
`timescale 1ns/1ps
`include "remap_router_regs.svh"
module input_route_mux #(
  parameter logic [127:0] PIN_MASK = `RR_IN_PIN_MASK
) (
  input wire logic [7:0] sel,
  input wire logic [127:0] pinLevels,
  input wire logic [5:0] virtLevels,
  input wire logic [4:0] cmpLevels,
  output logic routed
);
  logic [7:0] virtOfs;
  assign virtOfs = sel - `RR_IN_VIRT_FIRST;

  always_comb begin
    routed = 1'b0;
    case (sel)
      `RR_IN_COMPARATOR1_VIRTUAL_SOURCE: routed = cmpLevels[0];
      `RR_IN_CMP2: routed = cmpLevels[1];
      `RR_IN_CMP3: routed = cmpLevels[2];
      `RR_IN_CMP4: routed = cmpLevels[3];
      `RR_IN_CMP5: routed = cmpLevels[4];
      default: begin
        if (sel >= `RR_IN_VIRT_FIRST && sel <= `RR_IN_VIRT_LAST) begin
          routed = virtLevels[virtOfs[2:0]];
        end else if (!sel[7] && PIN_MASK[sel[6:0]] && sel != `RR_IN_TIE_LOW) begin
          routed = pinLevels[sel[6:0]];
        end
      end
    endcase
  end
endmodule

// file: src/output_route_mux.sv
// peripheral output selector for one remapper output
`timescale 1ns/1ps
`include "remap_router_regs.svh"
module output_route_mux (
  input wire logic [5:0] sel,
  input wire logic [63:0] periphLevels,
  output logic level,
  output logic active
);
  always_comb begin
    level = 1'b0;
    active = 1'b0;
    case (sel)
      `RR_OUT_UART1_TX, `RR_OUT_UART2_TX, `RR_OUT_CAN_TX,
      `RR_OUT_SPI2_DATA, `RR_OUT_SPI2_CLK, `RR_OUT_SPI2_SEL,
      `RR_OUT_COMPARE1, `RR_OUT_COMPARE1 + 6'h01,
      `RR_OUT_COMPARE1 + 6'h02, `RR_OUT_COMPARE1 + 6'h03,
      `RR_OUT_COMPARATOR1, `RR_OUT_COMPARATOR1 + 6'h01,
      `RR_OUT_COMPARATOR1 + 6'h02, `RR_OUT_COMPARATOR4,
      `RR_OUT_COMPARATOR4 + 6'h01,
      `RR_OUT_PWM_SYNC, `RR_OUT_REF_CLK, `RR_OUT_SENT1,
      `RR_OUT_SENT1 + 6'h01: begin
        level = periphLevels[sel];
        active = 1'b1;
      end
      default: begin
        level = 1'b0;
        active = 1'b0;
      end
    endcase
  end
endmodule

// file: src/remappable_pin_router.sv
// remappable pin router: apb selector registers, input and output routing, pad control
`timescale 1ns/1ps
`include "remap_router_regs.svh"

module remappable_pin_router (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] padIn,
  input wire logic coreOvervoltageDetect,
  input wire logic [127:0] portOut,
  input wire logic [127:0] pinDirectionBits,
  input wire logic [127:0] dedicatedOutEn,
  input wire logic [127:0] dedicatedOut,
  input wire logic [127:0] analogEn,
  input wire logic [4:0] comparatorOutputs,
  input wire logic uart1Transmit,
  input wire logic uart2Transmit,
  input wire logic spi2DataOut,
  input wire logic spi2ClockOut,
  input wire logic spi2SelectOut,
  input wire logic canTransmit,
  input wire logic [3:0] compareOutputs,
  input wire logic pwmSyncOutput,
  input wire logic referenceClockOut,
  input wire logic [1:0] sentTransmit,
  output logic [127:0] padOut,
  output logic [127:0] padOutEn,
  output logic extInterrupt1,
  output logic extInterrupt2,
  output logic timer2ExtClock,
  output logic capture1Input,
  output logic capture2Input,
  output logic capture3Input,
  output logic capture4Input,
  output logic compareFaultA,
  output logic pwmFault1Input,
  output logic pwmFault2Input,
  output logic uart1Receive,
  output logic uart2Receive,
  output logic spi2DataIn,
  output logic spi2ClockIn,
  output logic spi2SelectIn,
  output logic canReceive,
  output logic pwmSyncInput,
  output logic deadtimeCompInput1,
  output logic deadtimeCompInput2,
  output logic deadtimeCompInput3,
  output logic sent1Input,
  output logic sent2Input
);
  localparam int NUM_IN = int'(remap_router_pkg::IN_COUNT);
  localparam logic [181:0] OUT_MASK = `RR_OUT_IMPL_MASK;
  localparam logic [9:0] OUT_WORD_BASE = 10'(`RR_OUT_SEL_BASE >> 2);

  // two flops on every pad input and on the detector; only the second is read
  logic [127:0] padMeta_reg;
  logic [127:0] padSync_reg;
  logic ovpMeta_reg;
  logic ovpSync_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      padMeta_reg <= '0;
      padSync_reg <= '0;
      ovpMeta_reg <= 1'b0;
      ovpSync_reg <= 1'b0;
    end else begin
      padMeta_reg <= padIn;
      padSync_reg <= padMeta_reg;
      ovpMeta_reg <= coreOvervoltageDetect;
      ovpSync_reg <= ovpMeta_reg;
    end
  end

  // apb: setup cycle prepares the answer, so every access has no wait state
  logic setupPhase;
  logic accessDone;
  logic [9:0] wordIdx;
  logic [9:0] outIdx;
  logic aligned;
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wordIdx = paddr[11:2];
  assign outIdx = wordIdx - OUT_WORD_BASE;
  assign aligned = paddr[1:0] == 2'b00;

  remap_router_pkg::in_sel_t inSel_reg [NUM_IN];
  remap_router_pkg::out_sel_t outSel [`RR_NUM_REMAP];
  logic [NUM_IN-1:0] routed_reg;
  logic [NUM_IN-1:0] routedNext;

  logic [31:0] rdNext;
  logic hitNext;
  always_comb begin
    rdNext = 32'h0000_0000;
    hitNext = 1'b0;
    if (paddr < `RR_STATUS_OFS && wordIdx < 10'(NUM_IN)) begin
      hitNext = 1'b1;
      rdNext = {24'h00_0000, inSel_reg[wordIdx[4:0]]};
    end else if (paddr == `RR_STATUS_OFS) begin
      hitNext = 1'b1;
      rdNext = {31'h0, ovpSync_reg};
    end else if (paddr == `RR_ROUTED_OFS) begin
      hitNext = 1'b1;
      rdNext = {10'h000, routed_reg};
    end else if (paddr >= `RR_OUT_SEL_BASE && outIdx < 10'(`RR_NUM_REMAP)) begin
      hitNext = OUT_MASK[outIdx[7:0]];
      rdNext = {26'h000_0000, outSel[outIdx[7:0]]};
    end
    if (!aligned) begin
      hitNext = 1'b0;
      rdNext = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~hitNext;
      prdata <= (setupPhase & ~pwrite & hitNext) ? rdNext : 32'h0000_0000;
    end
  end

  // selectors are independent words; nothing checks one against another
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          inSel_reg[gi] <= `RR_IN_RESET;
        end else if (accessDone && pwrite && !pslverr && paddr < `RR_STATUS_OFS
                     && wordIdx == 10'(gi)) begin
          inSel_reg[gi] <= pwdata[7:0];
        end
      end
    end
    for (gi = 0; gi < `RR_NUM_REMAP; gi++) begin : g_out
      if (OUT_MASK[gi]) begin : g_impl
        remap_router_pkg::out_sel_t sel_reg;
        always_ff @(posedge ref_clk or posedge reset) begin
          if (reset) begin
            sel_reg <= `RR_OUT_RESET;
          end else if (accessDone && pwrite && !pslverr && paddr >= `RR_OUT_SEL_BASE
                       && outIdx == 10'(gi)) begin
            sel_reg <= pwdata[5:0];
          end
        end
        assign outSel[gi] = sel_reg;
      end else begin : g_none
        assign outSel[gi] = `RR_OUT_NULL;
      end
    end
  endgenerate

  // peripheral outputs laid out by selector code
  logic [63:0] periphLevels;
  always_comb begin
    periphLevels = 64'h0;
    periphLevels[`RR_OUT_UART1_TX] = uart1Transmit;
    periphLevels[`RR_OUT_UART2_TX] = uart2Transmit;
    periphLevels[`RR_OUT_CAN_TX] = canTransmit;
    periphLevels[`RR_OUT_SPI2_DATA] = spi2DataOut;
    periphLevels[`RR_OUT_SPI2_CLK] = spi2ClockOut;
    periphLevels[`RR_OUT_SPI2_SEL] = spi2SelectOut;
    periphLevels[`RR_OUT_COMPARE1 +: 4] = compareOutputs;
    periphLevels[`RR_OUT_COMPARATOR1 +: 3] = comparatorOutputs[2:0];
    periphLevels[`RR_OUT_COMPARATOR4 +: 2] = comparatorOutputs[4:3];
    periphLevels[`RR_OUT_PWM_SYNC] = pwmSyncOutput;
    periphLevels[`RR_OUT_REF_CLK] = referenceClockOut;
    periphLevels[`RR_OUT_SENT1 +: 2] = sentTransmit;
  end

  logic [`RR_NUM_REMAP-1:0] outLevel;
  logic [`RR_NUM_REMAP-1:0] outActive;
  generate
    for (gi = 0; gi < `RR_NUM_REMAP; gi++) begin : g_omux
      output_route_mux u_omux (
        .sel(outSel[gi]),
        .periphLevels(periphLevels),
        .level(outLevel[gi]),
        .active(outActive[gi])
      );
    end
  endgenerate

  // remapper outputs 176..181 reach no pad and loop back as input sources
  logic [5:0] virtLevels;
  assign virtLevels = outLevel[`RR_VIRT_FIRST_PIN +: 6];

  // analog-enabled pins read as low to every remapped input
  logic [127:0] pinLevels;
  assign pinLevels = padSync_reg & ~analogEn;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_imux
      input_route_mux #(
        .PIN_MASK(`RR_IN_PIN_MASK)
      ) u_imux (
        .sel(inSel_reg[gi]),
        .pinLevels(pinLevels),
        .virtLevels(virtLevels),
        .cmpLevels(comparatorOutputs),
        .routed(routedNext[gi])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      routed_reg <= '0;
    end else begin
      routed_reg <= routedNext;
    end
  end
  assign extInterrupt1 = routed_reg[remap_router_pkg::IN_EXT_EXT_INTERRUPT_1];
  assign extInterrupt2 = routed_reg[remap_router_pkg::IN_EXT_EXT_INTERRUPT_2];
  assign timer2ExtClock = routed_reg[remap_router_pkg::IN_TIMER2_CLK];
  assign capture1Input = routed_reg[remap_router_pkg::IN_CAPTURE1];
  assign capture2Input = routed_reg[remap_router_pkg::IN_CAPTURE2];
  assign capture3Input = routed_reg[remap_router_pkg::IN_CAPTURE3];
  assign capture4Input = routed_reg[remap_router_pkg::IN_CAPTURE4];
  assign compareFaultA = routed_reg[remap_router_pkg::IN_COMPARE_FAULT_A];
  assign pwmFault1Input = routed_reg[remap_router_pkg::IN_PWM_FAULT1];
  assign pwmFault2Input = routed_reg[remap_router_pkg::IN_PWM_FAULT2];
  assign uart1Receive = routed_reg[remap_router_pkg::IN_UART1_RX];
  assign uart2Receive = routed_reg[remap_router_pkg::IN_UART2_RX];
  assign spi2DataIn = routed_reg[remap_router_pkg::IN_SPI2_DATA];
  assign spi2ClockIn = routed_reg[remap_router_pkg::IN_SPI2_CLK];
  assign spi2SelectIn = routed_reg[remap_router_pkg::IN_SPI2_SEL];
  assign canReceive = routed_reg[remap_router_pkg::IN_CAN_RX];
  assign pwmSyncInput = routed_reg[remap_router_pkg::IN_PWM_SYNC];
  assign deadtimeCompInput1 = routed_reg[remap_router_pkg::IN_DEADTIME1];
  assign deadtimeCompInput2 = routed_reg[remap_router_pkg::IN_DEADTIME2];
  assign deadtimeCompInput3 = routed_reg[remap_router_pkg::IN_DEADTIME3];
  assign sent1Input = routed_reg[remap_router_pkg::IN_SENT1];
  assign sent2Input = routed_reg[remap_router_pkg::IN_SENT2];

  // pad drive priority: overvoltage, dedicated, remapped, default port
  generate
    for (gi = 0; gi < `RR_NUM_PADS; gi++) begin : g_pad
      logic remapDrive;
      assign remapDrive = outActive[gi] & ~analogEn[gi];
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          padOut[gi] <= 1'b0;
          padOutEn[gi] <= 1'b0;
        end else if (ovpSync_reg) begin
          padOut[gi] <= 1'b0;
          padOutEn[gi] <= 1'b0;
        end else if (dedicatedOutEn[gi]) begin
          padOut[gi] <= dedicatedOut[gi];
          padOutEn[gi] <= 1'b1;
        end else if (remapDrive) begin
          padOut[gi] <= outLevel[gi];
          padOutEn[gi] <= 1'b1;
        end else begin
          padOut[gi] <= portOut[gi];
          padOutEn[gi] <= ~pinDirectionBits[gi];
        end
      end

      a_remap_drives: assert property (@(posedge ref_clk) disable iff (reset)
        (!ovpSync_reg && !dedicatedOutEn[gi] && remapDrive)
        |=> (padOutEn[gi] && padOut[gi] == $past(outLevel[gi])))
        else $error("remapped output not on pad");
      a_dedicated_wins: assert property (@(posedge ref_clk) disable iff (reset)
        (!ovpSync_reg && dedicatedOutEn[gi])
        |=> (padOutEn[gi] && padOut[gi] == $past(dedicatedOut[gi])))
        else $error("dedicated output lost priority");
      a_null_default: assert property (@(posedge ref_clk) disable iff (reset)
        (!ovpSync_reg && !dedicatedOutEn[gi] && !outActive[gi])
        |=> (padOut[gi] == $past(portOut[gi])
             && padOutEn[gi] == !$past(pinDirectionBits[gi])))
        else $error("null selection did not leave port drive");
    end
  endgenerate

  a_ovp_tristate: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(ovpSync_reg) |=> (padOutEn == '0) [*2])
    else $error("pads driven during overvoltage");
  a_out_reset: assert property (@(posedge ref_clk) disable iff (reset)
    $past(reset) |-> (outSel[20] == `RR_OUT_NULL && padOutEn == '0))
    else $error("output selector not null after reset");
  a_fault1_cmp: assert property (@(posedge ref_clk) disable iff (reset)
    (inSel_reg[remap_router_pkg::IN_PWM_FAULT1] == `RR_IN_COMPARATOR1_VIRTUAL_SOURCE)
    |=> (pwmFault1Input == $past(comparatorOutputs[0])))
    else $error("fault input not following comparator 1");
  a_virtual_source: assert property (@(posedge ref_clk) disable iff (reset)
    (inSel_reg[0] == `RR_IN_VIRT_LAST) |=> (extInterrupt1 == $past(virtLevels[5])))
    else $error("virtual source not routed");
  a_invalid_low: assert property (@(posedge ref_clk) disable iff (reset)
    (inSel_reg[7] == `RR_IN_TIE_LOW || inSel_reg[7] == 8'h05 || inSel_reg[7] == 8'h15
     || inSel_reg[7] > 8'hb5)
    |=> !compareFaultA)
    else $error("unimplemented input code not low");
  a_pin_route: assert property (@(posedge ref_clk) disable iff (reset)
    (inSel_reg[2] == 8'h23) |=> (timer2ExtClock == $past(pinLevels[35])))
    else $error("pin source not routed");
  a_apb_single: assert property (@(posedge ref_clk) disable iff (reset)
    setupPhase |=> (pready ##1 !pready))
    else $error("apb answer not exactly one cycle");
  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (reset)
    (setupPhase && paddr == 12'h0fc) |=> (pslverr && prdata == 32'h0))
    else $error("unmapped address not refused");
endmodule

// file: bench/far_side_model.sv
// peripheral outputs and pad cells facing the pin router
`timescale 1ns/1ps
module far_side_model (
  input wire logic [13:0] periphDrive,
  input wire logic [127:0] extLevels,
  input wire logic [127:0] padOut,
  input wire logic [127:0] padOutEn,
  output logic [127:0] padIn,
  output logic uart1Transmit,
  output logic uart2Transmit,
  output logic spi2DataOut,
  output logic spi2ClockOut,
  output logic spi2SelectOut,
  output logic canTransmit,
  output logic [3:0] compareOutputs,
  output logic pwmSyncOutput,
  output logic referenceClockOut,
  output logic [1:0] sentTransmit
);
  // a driven pad reads back its own level, an undriven one the outside world
  assign padIn = (padOut & padOutEn) | (extLevels & ~padOutEn);
  assign {sentTransmit, referenceClockOut, pwmSyncOutput, compareOutputs, canTransmit,
    spi2SelectOut, spi2ClockOut, spi2DataOut, uart2Transmit, uart1Transmit} = periphDrive;
endmodule

// file: bench/tb.sv
// self-checking bench for the remappable pin router
`timescale 1ns/1ps
module tb;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, coreOvervoltageDetect;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [127:0] padIn, padOut, padOutEn, portOut, pinDirectionBits, dedicatedOutEn;
  logic [127:0] dedicatedOut, analogEn, extLevels;
  logic [13:0] periphDrive;
  logic [4:0] comparatorOutputs;
  logic uart1Transmit, uart2Transmit, spi2DataOut, spi2ClockOut, spi2SelectOut, canTransmit;
  logic pwmSyncOutput, referenceClockOut;
  logic [3:0] compareOutputs;
  logic [1:0] sentTransmit;
  logic [21:0] routed;
  logic e;
  int errCount, nCompared;
  logic [5:0] outCode [19] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11,
    6'h12, 6'h13, 6'h2d, 6'h31, 6'h39, 6'h3a, 6'h18, 6'h19, 6'h1a, 6'h32, 6'h33};
  logic [7:0] inCode [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0c, 8'h00, 8'h05, 8'h15, 8'h01};

  remappable_pin_router dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .padIn, .coreOvervoltageDetect, .portOut, .pinDirectionBits,
    .dedicatedOutEn, .dedicatedOut, .analogEn, .comparatorOutputs, .uart1Transmit,
    .uart2Transmit, .spi2DataOut, .spi2ClockOut, .spi2SelectOut, .canTransmit,
    .compareOutputs, .pwmSyncOutput, .referenceClockOut, .sentTransmit, .padOut, .padOutEn,
    .extInterrupt1(routed[0]), .extInterrupt2(routed[1]), .timer2ExtClock(routed[2]),
    .capture1Input(routed[3]), .capture2Input(routed[4]), .capture3Input(routed[5]),
    .capture4Input(routed[6]), .compareFaultA(routed[7]), .pwmFault1Input(routed[8]),
    .pwmFault2Input(routed[9]), .uart1Receive(routed[10]), .uart2Receive(routed[11]),
    .spi2DataIn(routed[12]), .spi2ClockIn(routed[13]), .spi2SelectIn(routed[14]),
    .canReceive(routed[15]), .pwmSyncInput(routed[16]), .deadtimeCompInput1(routed[17]),
    .deadtimeCompInput2(routed[18]), .deadtimeCompInput3(routed[19]),
    .sent1Input(routed[20]), .sent2Input(routed[21]));

  far_side_model partner (.periphDrive, .extLevels, .padOut, .padOutEn, .padIn,
    .uart1Transmit, .uart2Transmit, .spi2DataOut, .spi2ClockOut, .spi2SelectOut,
    .canTransmit, .compareOutputs, .pwmSyncOutput, .referenceClockOut, .sentTransmit);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    if (errCount == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held from setup until pready is seen high, then released a full cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errCount++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic settle;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic t_reset;
    apb(1'b0, 12'h150, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h3c0, 32'h0);
    chk(q, 32'h0);
    chk(padOutEn[31:0] | padOutEn[63:32] | padOutEn[95:64] | padOutEn[127:96], 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h104, 32'h3f);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h104, 32'h0);
    chk({q[30:0], e}, 32'h1);
  endtask

  task automatic t_pin_inputs;
    for (int i = 0; i < 22; i++) apb(1'b1, 12'(4 * i), 32'h23);
    apb(1'b0, 12'h054, 32'h0);
    chk(q, 32'h23);
    extLevels[35] <= 1'b1;
    settle();
    chk(32'(routed), 32'h3fffff);
    apb(1'b0, 12'h0f4, 32'h0);
    chk(q, 32'h3fffff);
    analogEn[35] <= 1'b1;
    settle();
    chk(32'(routed), 32'h0);
    analogEn[35] <= 1'b0;
    extLevels[35] <= 1'b0;
    settle();
    chk(32'(routed), 32'h0);
  endtask

  task automatic t_in_codes;
    for (int i = 0; i < 22; i++) apb(1'b1, 12'(4 * i), 32'(i < 9 ? inCode[i] : 8'h00));
    extLevels <= '1;
    comparatorOutputs <= 5'h15;
    settle();
    chk(32'(routed), 32'h115);
    comparatorOutputs <= 5'h0a;
    settle();
    chk(32'(routed), 32'h00a);
    comparatorOutputs <= 5'h00;
    settle();
    chk(32'(routed), 32'h0);
  endtask

  task automatic t_virtual;
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, 12'(12'h3c0 + 4 * k), 32'(outCode[k]));
      apb(1'b1, 12'(4 * k), 32'(8'hb0 + k));
    end
    periphDrive <= 14'h15;
    settle();
    chk(32'(routed), 32'h15);
    periphDrive <= 14'h2a;
    settle();
    chk(32'(routed), 32'h2a);
    apb(1'b1, 12'h000, 32'hb5);
    settle();
    chk(32'(routed), 32'h2b);
  endtask

  task automatic t_out_codes;
    for (int i = 0; i < 19; i++) begin
      apb(1'b1, 12'h150, 32'(outCode[i]));
      {comparatorOutputs, periphDrive} <= 19'h7ffff ^ (19'h1 << i);
      settle();
      chk({30'h0, padOutEn[20], padOut[20]}, 32'h2);
      {comparatorOutputs, periphDrive} <= 19'h1 << i;
      settle();
      chk({30'h0, padOutEn[20], padOut[20]}, 32'h3);
    end
    apb(1'b1, 12'h150, 32'h02);
    settle();
    chk({30'h0, padOutEn[20], padOut[20]}, 32'h1);
    pinDirectionBits[20] <= 1'b0;
    apb(1'b1, 12'h150, 32'h01);
    apb(1'b1, 12'h18c, 32'h01);
    periphDrive <= 14'h0;
    portOut[20] <= 1'b0;
    settle();
    chk({30'h0, padOut[35], padOut[20]}, 32'h0);
    periphDrive <= 14'h1;
    settle();
    chk({30'h0, padOut[35], padOut[20]}, 32'h3);
    apb(1'b1, 12'h150, 32'h00);
    settle();
    chk({30'h0, padOutEn[20], padOut[20]}, 32'h2);
    pinDirectionBits[20] <= 1'b1;
  endtask

  task automatic t_priority;
    apb(1'b1, 12'h150, 32'h01);
    dedicatedOutEn[20] <= 1'b1;
    settle();
    chk({30'h0, padOutEn[20], padOut[20]}, 32'h2);
    dedicatedOutEn[20] <= 1'b0;
    analogEn[20] <= 1'b1;
    settle();
    chk({30'h0, padOutEn[20], padOut[20]}, 32'h0);
    analogEn[20] <= 1'b0;
    coreOvervoltageDetect <= 1'b1;
    settle();
    chk(padOutEn[31:0] | padOutEn[63:32] | padOutEn[95:64] | padOutEn[127:96], 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(q, 32'h1);
    coreOvervoltageDetect <= 1'b0;
    settle();
    chk({30'h0, padOutEn[20], padOut[20]}, 32'h3);
  endtask

  initial begin
    errCount = 0;
    nCompared = 0;
    reset = 1'b1;
    {psel, penable, pwrite, coreOvervoltageDetect} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    portOut = '1;
    pinDirectionBits = '1;
    {dedicatedOutEn, dedicatedOut, analogEn, extLevels} = '0;
    periphDrive = 14'h0;
    comparatorOutputs = 5'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_pin_inputs();
    t_in_codes();
    t_virtual();
    t_out_codes();
    t_priority();
    summarize();
  end
endmodule
